// ==== logic/swc_pkg.sv ====
// Purpose: Constants and types for the sleep and wake-up controller
// Assumes: 100 MHz clock, 14-bit register port
// Notes:   Shared by the controller and its bench
package swc_pkg;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 14;
  localparam int          DATA_W       = 14;
  localparam logic [13:0] ADR_STATUS   = 14'h0000;
  localparam logic [13:0] ADR_FLAGS    = 14'h0001;
  localparam logic [13:0] ADR_ENABLE   = 14'h0002;
  localparam logic [13:0] ADR_ID_BASE  = 14'h2000;
  localparam int          ID_WORDS     = 4;
  localparam int          PD_BIT       = 3;
  localparam int          TO_BIT       = 4;
  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int          NSRC         = 6;
  localparam int          SRC_INT      = 0;
  localparam int          SRC_RB       = 1;
  localparam int          SRC_SIXTEEN_BIT_TIMER     = 2;
  localparam int          SRC_CAP      = 3;
  localparam int          SRC_SPEC     = 4;
  localparam int          SRC_OTHER    = 5;
  // ----------------------------------------------------------------
  // Core timing
  // ----------------------------------------------------------------
  localparam int          PC_W         = 13;
  localparam logic [12:0] INT_VECTOR   = 13'h0004;
  localparam logic [1:0]  LAST_PHASE   = 2'h3;
  localparam logic [1:0]  CP_UNPROG    = 2'h3;
  localparam int          CLK_NS       = 10;
  localparam int          OSC_START_NS = 100;
  localparam int          OSC_START_CYC = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_WAKE} swc_state_type;
endpackage : swc_pkg

// ==== logic/swc_sleep_ctrl.sv ====
// Purpose: Sleep entry, wake-up and status flags of a small core
// Assumes: i_clk is the always-on wake clock; core runs while osc drive on
// Notes:   Functional notes below
// Functional notes
// - Sleep is entered only by executing the sleep instruction.
// - Entry clears watchdog, clears power-down, sets time-out, stops oscillator.
// - I/O pins hold their drive state throughout sleep.
// - Wake on reset pin, enabled watchdog time-out, or enabled interrupt.
// - Reset pin wake resets device; other wakes resume execution.
// - Power-down set at power-up; time-out cleared on watchdog time-out.
// - Peripheral wake only from async timer, capture, async special trigger.
// - Clock-dependent peripherals raise no interrupts during sleep.
// - Sleep execution prefetches the next program address.
// - Wake needs source enable; global enable does not matter.
// - After wake run next instruction, then vector if global enable set.
// - Pending enabled flag makes sleep a no-operation, flags untouched.
// - Interrupt during or after sleep execution wakes immediately.
// - Verify readout only while code protection bits unprogrammed.
// - Four ID words reachable only in program/verify mode.
// - Instruction cycle is four clocks; branches add a no-operation cycle.
// - Flags set by events regardless of any enable.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module swc_sleep_ctrl #(
  parameter int OSC_CYC = swc_pkg::OSC_START_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_ce,
  input  wire logic [swc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [swc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [swc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                       i_sleep_instr,
  input  wire logic                       i_watchdog_clear_instr,
  input  wire logic                       i_pc_change,
  input  wire logic [swc_pkg::PC_W-1:0]   i_pc,
  input  wire logic                       i_global_irq_enable,
  input  wire logic                       i_ext_reset_pin_n,
  input  wire logic                       i_wdt_enable,
  input  wire logic                       i_wdt_timeout,
  input  wire logic [swc_pkg::NSRC-1:0]   i_irq_event,
  input  wire logic                       i_timer_async,
  input  wire logic                       i_timer_ext_clk,
  input  wire logic                       i_capture_mode,
  input  wire logic                       i_prog_mode,
  input  wire logic [1:0]                 i_code_protect,
  output logic                            o_cycle_stb,
  output logic                            o_exec_nop,
  output logic                            o_prefetch,
  output logic      [swc_pkg::PC_W-1:0]   o_prefetch_addr,
  output logic                            o_wdt_clear,
  output logic                            o_osc_drive_en,
  output logic                            o_io_hold,
  output logic                            o_dev_reset,
  output logic                            o_vector_req,
  output logic      [swc_pkg::PC_W-1:0]   o_vector_addr,
  output logic                            o_verify_en
);
  import swc_pkg::*;

  initial begin
    if (OSC_CYC < 1 || OSC_CYC > 255) $error("OSC_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic            rst_s1_q, rst_s2_q;
  logic            wdt_s1_q, wdt_s2_q, wdt_s3_q;
  logic [NSRC-1:0] ev_s1_q, ev_s2_q, ev_s3_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      {rst_s1_q, rst_s2_q} <= 2'h3;
      {wdt_s1_q, wdt_s2_q, wdt_s3_q} <= 3'h0;
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
    end else if (i_ce) begin
      rst_s1_q <= i_ext_reset_pin_n;
      rst_s2_q <= rst_s1_q;
      wdt_s1_q <= i_wdt_timeout;
      wdt_s2_q <= wdt_s1_q;
      wdt_s3_q <= wdt_s2_q;
      ev_s1_q  <= i_irq_event;
      ev_s2_q  <= ev_s1_q;
      ev_s3_q  <= ev_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode and event terms
  // ----------------------------------------------------------------
  swc_state_type   state_q, state_d;
  logic [1:0]      phase_q;
  logic [7:0]      osc_cnt_q;
  logic            pd_q, to_q, nop_q, vec_q;
  logic [NSRC-1:0] flag_q, enab_q;
  logic [DATA_W-1:0] id_mem [ID_WORDS];

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  wire             asleep     = (state_q == SWC_SLEEP);
  wire             ext_rst    = !rst_s2_q;
  wire             wdt_ev     = wdt_s2_q && !wdt_s3_q && i_wdt_enable;
  wire [NSRC-1:0]  ev_rise    = ev_s2_q & ~ev_s3_q;
  wire [NSRC-1:0]  sleep_ok   = {1'b0, i_timer_async & i_timer_ext_clk, i_capture_mode,
                                 i_timer_async, 2'h3};
  wire [NSRC-1:0]  ev_set     = asleep ? (ev_rise & sleep_ok) : ev_rise;
  wire [NSRC-1:0]  flag_clr   = (i_wr && hit(i_addr, ADR_FLAGS)) ? ~i_wdata[NSRC-1:0] : '0;
  wire             pending    = |(flag_q & enab_q);
  wire             wake_irq   = |(flag_q & enab_q & sleep_ok);
  wire             cyc_stb    = (state_q == SWC_RUN) && (phase_q == LAST_PHASE);
  wire             sleep_exec = cyc_stb && !nop_q && i_sleep_instr;
  wire             sleep_go   = sleep_exec && !pending;
  wire             watchdog_clear_instr     = cyc_stb && !nop_q && i_watchdog_clear_instr;
  wire             osc_done   = (osc_cnt_q == 8'(OSC_CYC - 1));
  wire             id_sel     = (i_addr[ADDR_W-1:2] == ADR_ID_BASE[ADDR_W-1:2]);
  wire [1:0]       id_idx     = i_addr[1:0];
  wire             id_wr      = i_wr && i_prog_mode && id_sel;
  wire [DATA_W-1:0] stat_word = DATA_W'({to_q, pd_q}) << PD_BIT;
  wire [DATA_W-1:0] rd_mux    = hit(i_addr, ADR_STATUS) ? stat_word :
                                hit(i_addr, ADR_FLAGS)  ? DATA_W'(flag_q) :
                                hit(i_addr, ADR_ENABLE) ? DATA_W'(enab_q) :
                                (id_sel && i_prog_mode) ? id_mem[id_idx] : '0;

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SWC_RUN:   if (sleep_go) state_d = SWC_SLEEP;
      SWC_SLEEP: if (ext_rst) state_d = SWC_RUN;
                 else if (wdt_ev || wake_irq) state_d = SWC_WAKE;
      SWC_WAKE:  if (ext_rst) state_d = SWC_RUN;
                 else if (osc_done) state_d = SWC_RUN;
      default:   state_d = SWC_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q   <= SWC_RUN;
      osc_cnt_q <= 8'h00;
    end else if (i_ce) begin
      state_q   <= state_d;
      osc_cnt_q <= (state_q == SWC_WAKE) ? osc_cnt_q + 8'h01 : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Instruction cycle and vectoring
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst || ext_rst) begin
      phase_q <= 2'h0;
      nop_q   <= 1'b0;
      vec_q   <= 1'b0;
    end else if (i_ce) begin
      if (state_q == SWC_RUN) phase_q <= phase_q + 2'h1;
      if (cyc_stb) nop_q <= !nop_q && i_pc_change;
      if (state_q == SWC_WAKE && osc_done) vec_q <= i_global_irq_enable;
      else if (cyc_stb && !nop_q) vec_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else if (i_ce) begin
      if (wdt_ev) to_q <= 1'b0;
      else if (sleep_go) begin
        pd_q <= 1'b0;
        to_q <= 1'b1;
      end else if (watchdog_clear_instr) begin
        pd_q <= 1'b1;
        to_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags and enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flag_q <= '0;
      enab_q <= '0;
    end else if (i_ce) begin
      flag_q <= (flag_q & ~flag_clr) | ev_set;
      if (i_wr && hit(i_addr, ADR_ENABLE)) enab_q <= i_wdata[NSRC-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && id_wr) id_mem[id_idx] <= i_wdata;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata         <= '0;
      o_prefetch_addr <= '0;
      o_dev_reset     <= 1'b0;
    end else if (i_ce) begin
      o_rdata     <= i_rd ? rd_mux : '0;
      o_dev_reset <= ext_rst || (wdt_ev && !asleep);
      if (sleep_exec) o_prefetch_addr <= i_pc + PC_W'(1);
    end
  end

  assign o_cycle_stb    = cyc_stb;
  assign o_exec_nop     = cyc_stb && nop_q;
  assign o_prefetch     = sleep_exec;
  assign o_wdt_clear    = sleep_go || watchdog_clear_instr;
  assign o_osc_drive_en = !asleep;
  assign o_io_hold      = asleep;
  assign o_vector_req   = cyc_stb && !nop_q && vec_q;
  assign o_vector_addr  = INT_VECTOR;
  assign o_verify_en    = i_prog_mode && (i_code_protect == CP_UNPROG);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_wake_gie;
    i_ce && state_q == SWC_WAKE && osc_done && i_global_irq_enable && !ext_rst;
  endsequence

  sleep_entry_a: assert property (i_ce && sleep_go && !wdt_ev |=> asleep && !pd_q && to_q)
    else $error("sleep entry wrong");
  sleep_nop_a: assert property (i_ce && sleep_exec && pending && !wdt_ev && !watchdog_clear_instr
    |=> state_q == SWC_RUN && $stable(pd_q) && $stable(to_q))
    else $error("sleep not a nop");
  io_hold_a: assert property (asleep |-> o_io_hold && !o_osc_drive_en)
    else $error("io not held");
  reset_wake_a: assert property (i_ce && asleep && ext_rst |=> o_dev_reset && state_q == SWC_RUN)
    else $error("reset wake wrong");
  wdt_wake_a: assert property (i_ce && asleep && wdt_ev && !ext_rst |=> !to_q && state_q == SWC_WAKE)
    else $error("watchdog wake wrong");
  irq_wake_a: assert property (i_ce && asleep && wake_irq && !ext_rst |=> state_q == SWC_WAKE)
    else $error("irq wake missing");
  vector_after_a: assert property (s_wake_gie ##1 (i_ce && !ext_rst)[*4] |-> o_vector_req)
    else $error("vector missing");
  sleep_mask_a: assert property (i_ce && asleep && ev_rise[SRC_OTHER] && !flag_q[SRC_OTHER]
    |=> !flag_q[SRC_OTHER])
    else $error("clocked irq in sleep");
  flag_set_a: assert property (i_ce && ev_set[SRC_INT] && flag_clr[SRC_INT] |=> flag_q[SRC_INT])
    else $error("flag set lost");
  verify_a: assert property (o_verify_en |-> i_code_protect == CP_UNPROG && i_prog_mode)
    else $error("verify while protected");
endmodule : swc_sleep_ctrl

// ==== verif/swc_src_model.sv ====
// Purpose: Model of the interrupt sources and watchdog beside the controller
// Assumes: Event lines are levels; a rising edge is the event
// Notes:   Each pulse is held long enough to cross the two-flop synchroniser
`timescale 1ns/10ps
module swc_src_model (
  input  wire logic                     i_clk,
  output logic                          o_wdt_timeout,
  output logic      [swc_pkg::NSRC-1:0] o_irq_event
);
  import swc_pkg::*;
  initial begin
    o_wdt_timeout = 1'b0;
    o_irq_event   = '0;
  end
  // ----------------------------------------------------------------
  // Event pulse, index NSRC means watchdog time-out
  // ----------------------------------------------------------------
  task automatic pulse(input int idx);
    @(posedge i_clk);
    if (idx == NSRC) o_wdt_timeout <= 1'b1;
    else o_irq_event[idx] <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_wdt_timeout <= 1'b0;
    o_irq_event   <= '0;
  endtask : pulse
endmodule : swc_src_model

// ==== verif/tb_swc_sleep_ctrl.sv ====
// Purpose: Self-checking bench for the sleep and wake-up controller
// Assumes: Inputs driven by non-blocking assignment at the rising edge
// Notes:   Outputs sampled at the falling edge
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_swc_sleep_ctrl;
  import swc_pkg::*;
  logic              i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_sleep = 0, i_clr = 0;
  logic              i_gie = 0, i_rst_pin_n = 1, i_tasync = 0, i_prog = 0, i_pcc = 0, i_capm = 0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [1:0]        i_cp = 2'h3;
  logic [DATA_W-1:0] o_rdata;
  logic [PC_W-1:0]   o_pf_addr, o_vec_addr;
  logic [NSRC-1:0]   irq;
  logic              wdt_to, o_stb, o_nop, o_pf, o_wclr, o_osc, o_hold, o_dres, o_vreq, o_ver, pf, wc;
  int                n_errors = 0, compares = 0;
  always #5 i_clk = ~i_clk;
  swc_src_model u_src (.i_clk(i_clk), .o_wdt_timeout(wdt_to), .o_irq_event(irq));
  swc_sleep_ctrl #(.OSC_CYC(4)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_instr(i_sleep),
    .i_watchdog_clear_instr(i_clr), .i_pc_change(i_pcc), .i_pc(13'h0123), .i_global_irq_enable(i_gie),
    .i_ext_reset_pin_n(i_rst_pin_n), .i_wdt_enable(1'b1), .i_wdt_timeout(wdt_to), .i_irq_event(irq),
    .i_timer_async(i_tasync), .i_timer_ext_clk(1'b0), .i_capture_mode(i_capm), .i_prog_mode(i_prog),
    .i_code_protect(i_cp), .o_cycle_stb(o_stb), .o_exec_nop(o_nop), .o_prefetch(o_pf),
    .o_prefetch_addr(o_pf_addr), .o_wdt_clear(o_wclr), .o_osc_drive_en(o_osc), .o_io_hold(o_hold),
    .o_dev_reset(o_dres), .o_vector_req(o_vreq), .o_vector_addr(o_vec_addr), .o_verify_en(o_ver));
  // ----------------------------------------------------------------
  // Access and instruction tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    `CHK("rdata", e, o_rdata)
  endtask : rd
  task automatic exec(input logic s, input logic c);
    @(posedge i_clk);
    i_sleep <= s; i_clr <= c;
    for (int k = 0; k < 12; k++) begin
      @(negedge i_clk);
      if (o_stb === 1'b1 && o_nop === 1'b0) break;
    end
    pf = o_pf; wc = o_wclr;
    @(posedge i_clk);
    i_sleep <= 1'b0; i_clr <= 1'b0;
    @(negedge i_clk);
  endtask : exec
  task automatic wake();
    for (int k = 0; k < 100 && o_osc !== 1'b1; k++) @(negedge i_clk);
    `CHK("osc_on", 1'b1, o_osc)
  endtask : wake
  task automatic vec(input int n, input logic e);
    logic v = 1'b0;
    repeat (n) begin @(negedge i_clk); v |= (o_vreq === 1'b1); end
    `CHK("vector", e, v)
  endtask : vec
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ADR_STATUS, 14'h0018);
    rd(14'h0005, 14'h0000);
    wr(ADR_ENABLE, 14'h0001);
    rd(ADR_ENABLE, 14'h0001);
    wr(ADR_ID_BASE, 14'h000a);
    rd(ADR_ID_BASE, 14'h0000);
    @(posedge i_clk) i_prog <= 1'b1;
    wr(ADR_ID_BASE + 14'h0003, 14'h0005);
    rd(ADR_ID_BASE + 14'h0003, 14'h0005);
    `CHK("verify", 1'b1, o_ver)
    @(posedge i_clk) i_cp <= 2'h1;
    @(negedge i_clk) `CHK("verify", 1'b0, o_ver)
    @(posedge i_clk) i_prog <= 1'b0;
    exec(1'b0, 1'b1);
    `CHK("osc", 1'b1, o_osc)
    exec(1'b1, 1'b0);
    `CHK("prefetch", 1'b1, pf)
    `CHK("pf_addr", 13'h0124, o_pf_addr)
    `CHK("wdt_clr", 1'b1, wc)
    `CHK("osc", 1'b0, o_osc)
    `CHK("io_hold", 1'b1, o_hold)
    rd(ADR_STATUS, 14'h0010);
    u_src.pulse(SRC_INT);
    wake();
    vec(40, 1'b0);
    exec(1'b0, 1'b0);
    exec(1'b0, 1'b1);
    exec(1'b1, 1'b0);
    `CHK("wdt_clr", 1'b0, wc)
    `CHK("osc", 1'b1, o_osc)
    rd(ADR_STATUS, 14'h0018);
    wr(ADR_FLAGS, 14'h0000);
    wr(ADR_ENABLE, 14'h0024);
    @(posedge i_clk) begin i_tasync <= 1'b1; i_gie <= 1'b1; end
    exec(1'b1, 1'b0);
    u_src.pulse(SRC_OTHER);
    repeat (30) @(negedge i_clk);
    `CHK("osc", 1'b0, o_osc)
    u_src.pulse(SRC_SIXTEEN_BIT_TIMER);
    wake();
    vec(60, 1'b1);
    `CHK("vec_addr", 13'h0004, o_vec_addr)
    @(posedge i_clk) i_gie <= 1'b0;
    wr(ADR_FLAGS, 14'h0000);
    wr(ADR_ENABLE, 14'h0000);
    exec(1'b1, 1'b0);
    u_src.pulse(NSRC);
    wake();
    `CHK("dev_reset", 1'b0, o_dres)
    rd(ADR_STATUS, 14'h0000);
    exec(1'b1, 1'b0);
    @(posedge i_clk) i_rst_pin_n <= 1'b0;
    for (int k = 0; k < 10 && o_dres !== 1'b1; k++) @(negedge i_clk);
    `CHK("dev_reset", 1'b1, o_dres)
    @(posedge i_clk) i_rst_pin_n <= 1'b1;
    tally_and_finish();
  end
endmodule : tb_swc_sleep_ctrl
